/* File: hw/rtc_pit_core.sv */
`timescale 1ns/100ps
// Contract
// - Wrap count to zero at period, flag
// - Flag match when count equals compare
// - Periodic flag each selected interval
// - Every condition sets its flag bit
// - Request while enable and flag set
// - Separate flag/enable banks per source
// - Counter runs idle; standby needs keep bit
// - Periodic timer runs in any sleep
// - Slow clock; writes apply after sync
// - Four busy bits at status 0x01
// - Periodic control busy at 0x11 bit0
// - Halt stops counter unless run bit
// - Halt drives periodic output low unless run bit
// - High at break gives edge on resume
// - Low at break resumes low, quietly
// - Write one clears flag, zero keeps
// - Prescaler divides by two to n
// - Source select: osc, osc/32, ext
module rtc_pit_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_slow_i,
  input wire logic ext_slow_i,
  input wire logic sleep_idle_i,
  input wire logic sleep_standby_i,
  input wire logic cpu_halted_i,
  output logic counter_irq_o,
  output logic periodic_irq_o,
  output logic wrap_event_o,
  output logic match_event_o,
  output logic periodic_out_o
);
  // Bus side state
  logic ack_r; // Answer to the current cycle
  logic [31:0] rdata_r, rdata_nxt; // Registered read data
  logic req, wr; // New request not yet answered; write strobe
  logic [5:0] idx; // Word index
  // Software visible registers, as written
  logic [7:0] ctrl_sh_r, pctrl_sh_r; // Control bytes
  logic [15:0] per_sh_r, cmp_sh_r, cnt_sh_r; // Period, compare, count
  logic [1:0] inten_r, flags_r; // Counter enables and flags
  logic pinten_r, pflag_r; // Periodic enable and flag
  logic [7:0] temp_r; // Staging byte, plain storage
  logic dbg_run_r, pdbg_run_r; // Run through halt, per function
  logic [1:0] slow_clock_source_r; // Slow source choice
  // Copies used by the slow logic
  logic [7:0] ctrl_act_r, pctrl_act_r;
  logic [15:0] per_act_r, cmp_act_r;
  logic [15:0] cnt_r; // Live count
  // Slow clock and prescaler
  logic osc_rise, ext_rise, slow_tick; // Slow edges; selected tick
  logic [4:0] osc_div_r; // Divider for the 1 kHz choice
  logic [14:0] pre_r, pre_mask; // Shared prescaler and its tick mask
  logic pre_run, counter_run, cnt_tick, wrap_hit, match_hit;
  // Periodic timer
  logic pit_raw, pit_gated, pit_out_r, pit_nxt, pit_rise;
  // Synchronisation trackers: ctrl, cnt, per, cmp, pctrl
  logic [4:0] busy, apply, start;
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i;
  assign idx = wb_adr_i[7:2];
  // Answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      rdata_r <= rdata_nxt;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (idx)
      rtc_pit_pkg::IDX_CTRL: rdata_nxt[7:0] = ctrl_sh_r;
      rtc_pit_pkg::IDX_STATUS: rdata_nxt[3:0] = busy[3:0];
      rtc_pit_pkg::IDX_INTEN: rdata_nxt[1:0] = inten_r;
      rtc_pit_pkg::IDX_INTFLAG: rdata_nxt[1:0] = flags_r;
      rtc_pit_pkg::IDX_TEMP: rdata_nxt[7:0] = temp_r;
      rtc_pit_pkg::IDX_DBG: rdata_nxt[0] = dbg_run_r;
      rtc_pit_pkg::IDX_SLOW_CLOCK_SOURCE: rdata_nxt[1:0] = slow_clock_source_r;
      rtc_pit_pkg::IDX_CNT: rdata_nxt[15:0] = cnt_r;
      rtc_pit_pkg::IDX_PER: rdata_nxt[15:0] = per_sh_r;
      rtc_pit_pkg::IDX_CMP: rdata_nxt[15:0] = cmp_sh_r;
      rtc_pit_pkg::IDX_PCTRL: rdata_nxt[7:0] = pctrl_sh_r;
      rtc_pit_pkg::IDX_PSTATUS: rdata_nxt[0] = busy[4];
      rtc_pit_pkg::IDX_PINTEN: rdata_nxt[0] = pinten_r;
      rtc_pit_pkg::IDX_PINTFLAG: rdata_nxt[0] = pflag_r;
      rtc_pit_pkg::IDX_PDBG: rdata_nxt[0] = pdbg_run_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
    if (!req || wb_we_i) begin
      rdata_nxt = 32'h0000_0000;
    end
  end

  // Writes that must cross into the slow logic start a tracker
  assign start[0] = wr && wb_sel_i[0] && idx == rtc_pit_pkg::IDX_CTRL;
  assign start[1] = wr && |wb_sel_i[1:0] && idx == rtc_pit_pkg::IDX_CNT;
  assign start[2] = wr && |wb_sel_i[1:0] && idx == rtc_pit_pkg::IDX_PER;
  assign start[3] = wr && |wb_sel_i[1:0] && idx == rtc_pit_pkg::IDX_CMP;
  assign start[4] = wr && wb_sel_i[0] && idx == rtc_pit_pkg::IDX_PCTRL;

  // One tracker per synchronised register; a rewrite while busy
  // restarts the wait, which is why software checks busy first
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      rtc_sync_tracker #(
        .TICKS(rtc_pit_pkg::SYNC_TICKS)
      ) u_trk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start[g]),
        .slow_tick_i(slow_tick),
        .busy_o(busy[g]),
        .apply_o(apply[g])
      );
    end
  endgenerate

  // Plain control registers written straight from the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inten_r <= 2'h0;
      pinten_r <= 1'b0;
      temp_r <= 8'h00;
      dbg_run_r <= 1'b0;
      pdbg_run_r <= 1'b0;
      slow_clock_source_r <= 2'h0;
    end else if (wr && wb_sel_i[0]) begin
      case (idx)
        rtc_pit_pkg::IDX_INTEN: inten_r <= wb_dat_i[1:0];
        rtc_pit_pkg::IDX_PINTEN: pinten_r <= wb_dat_i[0];
        rtc_pit_pkg::IDX_TEMP: temp_r <= wb_dat_i[7:0];
        rtc_pit_pkg::IDX_DBG: dbg_run_r <= wb_dat_i[0];
        rtc_pit_pkg::IDX_PDBG: pdbg_run_r <= wb_dat_i[0];
        rtc_pit_pkg::IDX_SLOW_CLOCK_SOURCE: slow_clock_source_r <= wb_dat_i[1:0];
        default: slow_clock_source_r <= slow_clock_source_r;
      endcase
    end
  end
  // Shadow copies, readable at once except the count; bytes follow their lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_sh_r <= rtc_pit_pkg::CTRL_RESET;
      pctrl_sh_r <= rtc_pit_pkg::PCTRL_RESET;
      per_sh_r <= rtc_pit_pkg::PER_RESET;
      cmp_sh_r <= rtc_pit_pkg::CMP_RESET;
      cnt_sh_r <= rtc_pit_pkg::CNT_RESET;
    end else begin
      if (start[0]) ctrl_sh_r <= wb_dat_i[7:0];
      if (start[4]) pctrl_sh_r <= wb_dat_i[7:0];
      for (int b = 0; b < 2; b++) begin
        if (wb_sel_i[b]) begin
          if (start[1]) cnt_sh_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          if (start[2]) per_sh_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          if (start[3]) cmp_sh_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end
  // Slow side copies take the value only when the wait ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_act_r <= rtc_pit_pkg::CTRL_RESET;
      per_act_r <= rtc_pit_pkg::PER_RESET;
      cmp_act_r <= rtc_pit_pkg::CMP_RESET;
      pctrl_act_r <= rtc_pit_pkg::PCTRL_RESET;
    end else begin
      if (apply[0]) ctrl_act_r <= ctrl_sh_r;
      if (apply[2]) per_act_r <= per_sh_r;
      if (apply[3]) cmp_act_r <= cmp_sh_r;
      if (apply[4]) pctrl_act_r <= pctrl_sh_r;
    end
  end
  // Edges of the two slow inputs
  rtc_level_edge u_osc_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(osc_slow_i),
    .rise_o(osc_rise)
  );
  rtc_level_edge u_ext_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(ext_slow_i),
    .rise_o(ext_rise)
  );

  // Divide the oscillator for the low rate choice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_div_r <= 5'h00;
    end else if (osc_rise) begin
      osc_div_r <= osc_div_r + 5'h01;
    end
  end

  // Source select; the reserved code gives no slow clock at all
  always_comb begin
    case (slow_clock_source_r)
      rtc_pit_pkg::SRC_OSC: slow_tick = osc_rise;
      rtc_pit_pkg::SRC_OSC_DIV:
        slow_tick = osc_rise && osc_div_r == 5'(rtc_pit_pkg::OSC_DIV - 1);
      rtc_pit_pkg::SRC_EXT: slow_tick = ext_rise;
      default: slow_tick = 1'b0;
    endcase
  end

  // Prescaler runs while either function is on
  assign pre_run = ctrl_act_r[rtc_pit_pkg::CTRL_ON_BIT] |
                   pctrl_act_r[rtc_pit_pkg::PCTRL_ON_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= 15'h0000;
    end else if (!pre_run) begin
      pre_r <= 15'h0000;
    end else if (slow_tick) begin
      pre_r <= pre_r + 15'h0001;
    end
  end

  // Divide by two to the n: tick when the low n bits roll over
  assign pre_mask = 15'((16'h0001 <<
    ctrl_act_r[rtc_pit_pkg::CTRL_PRESC_LSB +: 4]) - 16'h0001);

  // Counter stops in standby without the keep bit, and in halt without the run bit
  assign counter_run = ctrl_act_r[rtc_pit_pkg::CTRL_ON_BIT] &&
    !(sleep_standby_i && !ctrl_act_r[rtc_pit_pkg::CTRL_STANDBY_BIT]) &&
    !(cpu_halted_i && !dbg_run_r);
  assign cnt_tick = counter_run && slow_tick &&
                    (pre_r & pre_mask) == pre_mask;
  assign wrap_hit = cnt_tick && cnt_r == per_act_r;
  assign match_hit = cnt_tick && cnt_r == cmp_act_r;

  // Count; a synchronised count write wins over the tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= rtc_pit_pkg::CNT_RESET;
    end else if (apply[1]) begin
      cnt_r <= cnt_sh_r;
    end else if (wrap_hit) begin
      cnt_r <= 16'h0000;
    end else if (cnt_tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Counter flags: set beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == rtc_pit_pkg::FLAG_WRAP_BIT && wrap_hit) ||
            (b == rtc_pit_pkg::FLAG_MATCH_BIT && match_hit)) begin
          flags_r[b] <= 1'b1;
        end else if (wr && wb_sel_i[0] && wb_dat_i[b] &&
                     idx == rtc_pit_pkg::IDX_INTFLAG) begin
          flags_r[b] <= 1'b0;
        end
      end
    end
  end

  // Event pulses for the rest of the chip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrap_event_o <= 1'b0;
      match_event_o <= 1'b0;
    end else begin
      wrap_event_o <= wrap_hit;
      match_event_o <= match_hit;
    end
  end

  // Periodic level follows one prescaler bit; ignores sleep
  always_comb begin
    pit_raw = 1'b0;
    if (pctrl_act_r[rtc_pit_pkg::PCTRL_ON_BIT] &&
        pctrl_act_r[rtc_pit_pkg::PCTRL_PER_LSB +: 4] != 4'h0 &&
        pctrl_act_r[rtc_pit_pkg::PCTRL_PER_LSB +: 4] <=
          rtc_pit_pkg::PIT_PER_MAX) begin
      pit_raw = pre_r[pctrl_act_r[rtc_pit_pkg::PCTRL_PER_LSB +: 4]];
    end
  end

  // Halt without run bit forces low; release restores the level, so
  // a level that was high comes back as a fresh edge
  assign pit_gated = cpu_halted_i && !pdbg_run_r;
  assign pit_nxt = pit_raw && !pit_gated;
  assign pit_rise = pit_nxt && !pit_out_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pit_out_r <= 1'b0;
    end else begin
      pit_out_r <= pit_nxt;
    end
  end
  assign periodic_out_o = pit_out_r;

  // Periodic flag, own bank; set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pflag_r <= 1'b0;
    end else if (pit_rise) begin
      pflag_r <= 1'b1;
    end else if (wr && wb_sel_i[0] && wb_dat_i[0] &&
                 idx == rtc_pit_pkg::IDX_PINTFLAG) begin
      pflag_r <= 1'b0;
    end
  end
  // Requests stand until the flag clears
  assign counter_irq_o = |(flags_r & inten_r);
  assign periodic_irq_o = pflag_r & pinten_r;
  // Checks
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_ack_timely: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing");
  a_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap_hit && !apply[1]) |=> (cnt_r == 16'h0000 && flags_r[0]))
    else $error("no wrap to zero");
  a_match_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_tick && cnt_r == cmp_act_r) |=> flags_r[1])
    else $error("match flag not set");
  a_both_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap_hit && match_hit) |=> (flags_r == 2'h3))
    else $error("flags not set together");
  a_irq_request: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_r[0] && inten_r[0]) |-> counter_irq_o)
    else $error("request not raised");
  a_pit_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(periodic_out_o) |-> pflag_r) else $error("periodic flag late");
  a_standby_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(sleep_standby_i && !ctrl_act_r[rtc_pit_pkg::CTRL_STANDBY_BIT]) |->
      $stable(cnt_r) || $past(apply[1])) else $error("ran in standby");
  a_idle_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_idle_i && !sleep_standby_i && !cpu_halted_i &&
     ctrl_act_r[rtc_pit_pkg::CTRL_ON_BIT]) |-> counter_run)
    else $error("counter stopped in idle");
  a_halt_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (cpu_halted_i && !pdbg_run_r) [*2] |-> !periodic_out_o)
    else $error("periodic output high in halt");
  a_busy_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
    start[0] |=> busy[0]) else $error("control busy missing");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_sel_i[0] && idx == rtc_pit_pkg::IDX_PINTFLAG &&
     wb_dat_i[0] && !pit_rise) |=> !pflag_r)
    else $error("flag not cleared");
endmodule

/* File: hw/rtc_pit_pkg.sv */
package rtc_pit_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_INTEN = 6'h02;
  localparam logic [5:0] IDX_INTFLAG = 6'h03;
  localparam logic [5:0] IDX_TEMP = 6'h04;
  localparam logic [5:0] IDX_DBG = 6'h05;
  localparam logic [5:0] IDX_SLOW_CLOCK_SOURCE = 6'h07;
  localparam logic [5:0] IDX_CNT = 6'h08;
  localparam logic [5:0] IDX_PER = 6'h0a;
  localparam logic [5:0] IDX_CMP = 6'h0c;
  localparam logic [5:0] IDX_PCTRL = 6'h10;
  localparam logic [5:0] IDX_PSTATUS = 6'h11;
  localparam logic [5:0] IDX_PINTEN = 6'h12;
  localparam logic [5:0] IDX_PINTFLAG = 6'h13;
  localparam logic [5:0] IDX_PDBG = 6'h15;

  // Control register fields
  localparam int CTRL_STANDBY_BIT = 7;
  localparam int CTRL_PRESC_LSB = 3;
  localparam int CTRL_ON_BIT = 0;
  localparam int PCTRL_PER_LSB = 3;
  localparam int PCTRL_ON_BIT = 0;

  // Flag and enable positions
  localparam int FLAG_WRAP_BIT = 0;
  localparam int FLAG_MATCH_BIT = 1;

  // Busy bit positions in the status register
  localparam int BUSY_CTRL_BIT = 0;
  localparam int BUSY_CNT_BIT = 1;
  localparam int BUSY_PER_BIT = 2;
  localparam int BUSY_CMP_BIT = 3;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] PER_RESET = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [7:0] PCTRL_RESET = 8'h00;

  // Slow clock source choices
  localparam logic [1:0] SRC_OSC = 2'h0;
  localparam logic [1:0] SRC_OSC_DIV = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // Timing: sync wait in slow ticks, oscillator divider, top period code
  localparam int SYNC_TICKS = 2;
  localparam int OSC_DIV = 32;
  localparam logic [3:0] PIT_PER_MAX = 4'he;
endpackage

/* File: hw/rtc_level_edge.sv */
`timescale 1ns/100ps
// Rising edge finder for a slow level sampled on clk_i
module rtc_level_edge (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic rise_o
);
  logic prev_r; // Level seen on the previous edge

  // Remember the level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_i;
    end
  end

  // One clk pulse per rising edge of the level
  assign rise_o = level_i & ~prev_r;
endmodule

/* File: hw/rtc_sync_tracker.sv */
`timescale 1ns/100ps
// Tracks one register write across a number of slow ticks
module rtc_sync_tracker #(
  parameter int TICKS = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic slow_tick_i,
  output logic busy_o,
  output logic apply_o
);
  logic [3:0] left_r; // Slow ticks still to wait
  logic [3:0] left_nxt;

  // Next count: a fresh write restarts the wait
  always_comb begin
    left_nxt = left_r;
    if (start_i) begin
      left_nxt = 4'(TICKS);
    end else if (slow_tick_i && left_r != 4'h0) begin
      left_nxt = left_r - 4'h1;
    end
  end

  // Counter state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_r <= 4'h0;
    end else begin
      left_r <= left_nxt;
    end
  end

  // Busy while waiting; apply on the last tick
  assign busy_o = left_r != 4'h0;
  assign apply_o = !start_i && slow_tick_i && left_r == 4'h1;
endmodule

/* File: verification/rtc_pit_interrupt_sync_regs_test.sv */
`timescale 1ns/100ps
module rtc_pit_interrupt_sync_regs_test;
  logic clk_i = 1'b0; // Bus side clock
  logic rst_i = 1'b1; // Held high for four edges
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic osc = 1'b0; // Slow oscillator, ten bus cycles a period
  logic ext = 1'b0; // External slow clock, never selected
  logic idle = 1'b0;
  logic stby = 1'b0;
  logic halt = 1'b0;
  logic [31:0] rdata;
  logic ack, cirq, pirq, wrap_ev, match_ev, pout;
  int n_fail = 0;
  int checks = 0;
  int seed = 98; // Fixed seed keeps runs repeatable
  int osc_cnt = 0;
  logic [31:0] q, q2, d;
  logic [3:0] s;
  logic [7:0] stage_exp = 8'h00; // Model of the staging byte
  logic seen_wrap = 1'b0; // Sticky copy of the wrap pulse
  logic seen_match = 1'b0; // Sticky copy of the match pulse

  rtc_pit_core dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(rdata), .wb_ack_o(ack),
    .osc_slow_i(osc), .ext_slow_i(ext), .sleep_idle_i(idle),
    .sleep_standby_i(stby), .cpu_halted_i(halt), .counter_irq_o(cirq),
    .periodic_irq_o(pirq), .wrap_event_o(wrap_ev),
    .match_event_o(match_ev), .periodic_out_o(pout)
  );

  // Clock: 40 ns period
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // Slow sources; the design samples them, so they move on clk_i edges
  always @(posedge clk_i) begin
    osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
    if (osc_cnt == 4) begin
      osc <= ~osc;
    end
    ext <= ~ext;
    if (wrap_ev === 1'b1) begin
      seen_wrap <= 1'b1;
    end
    if (match_ev === 1'b1) begin
      seen_match <= 1'b1;
    end
  end

  // Staging byte: only lane 0 lands
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] v,
                                       input logic [3:0] m);
    return m[0] ? v[7:0] : old;
  endfunction

  // One comparison, counted; mismatch reported at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; ack and data taken at a rising edge
  task automatic xfer(input logic [5:0] idx, input logic w,
                      input logic [31:0] v, input logic [3:0] m,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {idx, 2'b00};
    wb_sel <= m;
    wb_dat <= v;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({31'h0000_0000, ack}, 32'h0000_0001);
    r = rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] v);
    logic [31:0] r;
    xfer(idx, 1'b1, v, 4'hf, r);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] r);
    xfer(idx, 1'b0, 32'h0000_0000, 4'hf, r);
  endtask

  // Polls a status register until every busy bit has dropped
  task automatic wait_clear(input logic [5:0] idx);
    int n;
    logic [31:0] r;
    n = 0;
    do begin
      rd(idx, r);
      n++;
    end while (r !== 32'h0000_0000 && n < 50);
    chk(r, 32'h0000_0000);
  endtask

  // Bounded wait for a level on a design output
  task automatic wait_lvl(ref logic sig, input logic v, input int lim);
    int n;
    n = 0;
    while (sig !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk({31'h0000_0000, sig}, {31'h0000_0000, v});
  endtask

  // Does the count move over 100 bus cycles?
  task automatic cnt_moves(input logic mv);
    logic [31:0] a, b;
    rd(rtc_pit_pkg::IDX_CNT, a);
    repeat (100) @(posedge clk_i);
    rd(rtc_pit_pkg::IDX_CNT, b);
    chk({31'h0000_0000, a !== b}, {31'h0000_0000, mv});
  endtask

  task automatic set_halt(input logic v);
    @(posedge clk_i);
    halt <= v;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under this span
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, then an unmapped index that must read zero
    rd(rtc_pit_pkg::IDX_CTRL, q);
    chk(q, 32'h0000_0000);
    rd(rtc_pit_pkg::IDX_PER, q);
    chk(q, 32'h0000_ffff);
    rd(rtc_pit_pkg::IDX_CMP, q);
    chk(q, 32'h0000_0000);
    rd(rtc_pit_pkg::IDX_STATUS, q);
    chk(q, 32'h0000_0000);
    rd(rtc_pit_pkg::IDX_INTFLAG, q);
    chk(q, 32'h0000_0000);
    wr(6'h06, 32'h0000_00ff);
    rd(6'h06, q);
    chk(q, 32'h0000_0000);
    $display("test reset_map done");
    // Random byte-lane writes to the plain staging byte
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      s = $random(seed);
      xfer(rtc_pit_pkg::IDX_TEMP, 1'b1, d, s, q);
      stage_exp = lane0(stage_exp, d, s);
      rd(rtc_pit_pkg::IDX_TEMP, q);
      chk(q, {24'h00_0000, stage_exp});
    end
    $display("test staging done");
    // Reserved source gives no ticks, so a control write stays busy
    wr(rtc_pit_pkg::IDX_SLOW_CLOCK_SOURCE, 32'h0000_0002);
    wr(rtc_pit_pkg::IDX_CTRL, 32'h0000_0000);
    repeat (60) @(posedge clk_i);
    rd(rtc_pit_pkg::IDX_STATUS, q);
    chk(q, 32'h0000_0001);
    wr(rtc_pit_pkg::IDX_SLOW_CLOCK_SOURCE, 32'h0000_0000);
    wait_clear(rtc_pit_pkg::IDX_STATUS);
    $display("test reserved_source done");
    // Each synchronised write raises its own busy bit
    wr(rtc_pit_pkg::IDX_PER, 32'h0000_00ff);
    rd(rtc_pit_pkg::IDX_STATUS, q);
    chk(q, 32'h0000_0004);
    wait_clear(rtc_pit_pkg::IDX_STATUS);
    wr(rtc_pit_pkg::IDX_CMP, 32'h0000_0002);
    rd(rtc_pit_pkg::IDX_STATUS, q);
    chk(q, 32'h0000_0008);
    wait_clear(rtc_pit_pkg::IDX_STATUS);
    wr(rtc_pit_pkg::IDX_CNT, 32'h0000_0000);
    rd(rtc_pit_pkg::IDX_STATUS, q);
    chk(q, 32'h0000_0002);
    wait_clear(rtc_pit_pkg::IDX_STATUS);
    wr(rtc_pit_pkg::IDX_INTEN, 32'h0000_0003);
    wr(rtc_pit_pkg::IDX_CTRL, 32'h0000_0001);
    rd(rtc_pit_pkg::IDX_STATUS, q);
    chk(q, 32'h0000_0001);
    wait_clear(rtc_pit_pkg::IDX_STATUS);
    $display("test busy_flags done");
    // Match comes long before the wrap at 255
    wait_lvl(cirq, 1'b1, 300);
    rd(rtc_pit_pkg::IDX_INTFLAG, q);
    chk(q, 32'h0000_0002);
    chk({31'h0000_0000, seen_match}, 32'h0000_0001);
    wr(rtc_pit_pkg::IDX_INTFLAG, 32'h0000_0000);
    rd(rtc_pit_pkg::IDX_INTFLAG, q);
    chk(q, 32'h0000_0002);
    wr(rtc_pit_pkg::IDX_INTEN, 32'h0000_0001);
    chk({31'h0000_0000, cirq}, 32'h0000_0000);
    wr(rtc_pit_pkg::IDX_INTFLAG, 32'h0000_0002);
    rd(rtc_pit_pkg::IDX_INTFLAG, q);
    chk(q, 32'h0000_0000);
    wait_lvl(seen_wrap, 1'b1, 4000);
    rd(rtc_pit_pkg::IDX_CNT, q);
    chk({31'h0000_0000, q < 32'h0000_0002}, 32'h0000_0001);
    rd(rtc_pit_pkg::IDX_INTFLAG, q);
    chk(q & 32'h0000_0001, 32'h0000_0001);
    chk({31'h0000_0000, cirq}, 32'h0000_0001);
    $display("test counter_irq done");
    // Standby without the keep bit stops the count; idle does not
    stby <= 1'b1;
    cnt_moves(1'b0);
    stby <= 1'b0;
    idle <= 1'b1;
    cnt_moves(1'b1);
    idle <= 1'b0;
    // Halt stops the count unless the run bit is set
    wr(rtc_pit_pkg::IDX_DBG, 32'h0000_0000);
    set_halt(1'b1);
    cnt_moves(1'b0);
    wr(rtc_pit_pkg::IDX_DBG, 32'h0000_0001);
    cnt_moves(1'b1);
    set_halt(1'b0);
    $display("test sleep_debug done");
    // Periodic timer, period code 1, kept running in standby
    wr(rtc_pit_pkg::IDX_PINTEN, 32'h0000_0001);
    wr(rtc_pit_pkg::IDX_PCTRL, 32'h0000_0009);
    rd(rtc_pit_pkg::IDX_PSTATUS, q);
    chk(q, 32'h0000_0001);
    wait_clear(rtc_pit_pkg::IDX_PSTATUS);
    stby <= 1'b1;
    wr(rtc_pit_pkg::IDX_PINTFLAG, 32'h0000_0001);
    wait_lvl(pirq, 1'b1, 200);
    rd(rtc_pit_pkg::IDX_PINTFLAG, q);
    chk(q, 32'h0000_0001);
    wr(rtc_pit_pkg::IDX_PINTFLAG, 32'h0000_0001);
    chk({31'h0000_0000, pirq}, 32'h0000_0000);
    stby <= 1'b0;
    // Break while the output is high: an extra edge on resume
    wait_lvl(pout, 1'b1, 100);
    set_halt(1'b1);
    repeat (3) @(posedge clk_i);
    chk({31'h0000_0000, pout}, 32'h0000_0000);
    wr(rtc_pit_pkg::IDX_PINTFLAG, 32'h0000_0001);
    set_halt(1'b0);
    repeat (3) @(posedge clk_i);
    rd(rtc_pit_pkg::IDX_PINTFLAG, q);
    chk(q, 32'h0000_0001);
    // Break just after a fall: resumes low, no extra flag
    wait_lvl(pout, 1'b1, 100);
    wait_lvl(pout, 1'b0, 100);
    set_halt(1'b1);
    wr(rtc_pit_pkg::IDX_PINTFLAG, 32'h0000_0001);
    set_halt(1'b0);
    rd(rtc_pit_pkg::IDX_PINTFLAG, q);
    chk(q, 32'h0000_0000);
    $display("test periodic done");
    conclude();
  end
endmodule
